// file: shared/dap_pkg.sv
// Purpose: Shared constants and types for the dual serial audio port block
// Assumes: 8-bit registers on a simple write/read port, 100 MHz sys_clk
// Notes: Field positions match both port register pairs
package dap_pkg;
    localparam logic [7:0] DAP_OFS_A_WORD = 8'hc9;
    localparam logic [7:0] DAP_OFS_A_LINK = 8'hca;
    localparam logic [7:0] DAP_OFS_B_WORD = 8'hcb;
    localparam logic [7:0] DAP_OFS_B_LINK = 8'hcc;
    localparam logic [7:0] DAP_OFS_GROSS = 8'hd1;
    localparam logic [7:0] DAP_OFS_CHAN = 8'hd2;
    localparam logic [7:0] DAP_RST_REG = 8'h00;
    // Link control bit positions, then the count of used gross control bits
    localparam int DAP_RX_BIT = 2;
    localparam int DAP_SWAP_BIT = 3;
    localparam int DAP_WORD_SELECT_INVERT_BIT = 4;
    localparam int DAP_CKINV_BIT = 5;
    localparam int DAP_ROLE_BIT = 6;
    localparam int DAP_TX_BIT = 7;
    localparam int DAP_GROSS_USED = 6;
    // Rate generation: 64 bit clocks per frame, divided down from sys_clk
    localparam int DAP_SYS_HZ = 100000000;
    localparam int DAP_FS48_HZ = 48000;
    localparam int DAP_FS44_HZ = 44100;
    localparam int DAP_BCLK_PER_FRAME = 64;
    // Half bit period, rounded down, in sys_clk cycles
    localparam int DAP_HALF48 = DAP_SYS_HZ / (DAP_FS48_HZ * DAP_BCLK_PER_FRAME * 2);
    localparam int DAP_HALF44 = DAP_SYS_HZ / (DAP_FS44_HZ * DAP_BCLK_PER_FRAME * 2);
    localparam logic [1:0] DAP_FMT_I2S = 2'h0;
    localparam logic [1:0] DAP_FMT_LEFT = 2'h1;
    localparam logic [1:0] DAP_FMT_RIGHT = 2'h2;

    typedef struct packed {
        logic reference_rate_sel;
        logic [1:0] rate_multiplier;
        logic [2:0] divider;
        logic [1:0] word_length_sel;
    } dap_word_t;

    typedef struct packed {
        logic transmit_enable;
        logic role_select;
        logic serial_clock_invert;
        logic word_select_invert;
        logic channel_swap;
        logic receive_enable;
        logic [1:0] framing_sel;
    } dap_link_t;

    typedef struct packed {
        logic [23:0] left;
        logic [23:0] right;
    } dap_pair_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic standby;
        logic all_players_off;
        logic all_recorders_off;
        logic reference_off;
        logic digital_path_off;
        logic line_input_stage_off;
    } dap_gross_t;

    typedef struct packed {
        logic recorder_b_right_off;
        logic recorder_b_left_off;
        logic recorder_a_right_off;
        logic recorder_a_left_off;
        logic player_b_right_off;
        logic player_b_left_off;
        logic player_a_right_off;
        logic player_a_left_off;
    } dap_chan_t;
endpackage

// file: rtl/dap_port.sv
// Purpose: One serial audio port: clocking, framing, shift in and out
// Assumes: Link pins already synchronised by the caller
// Notes: Slot is 32 bit clocks per channel, data left-aligned in 24 bits
`timescale 1ns/10ps
module dap_port
    import dap_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Sync reset, active low
    input wire dap_pkg::dap_word_t word_cfg, // Word and rate setup
    input wire dap_pkg::dap_link_t link_cfg, // Link setup
    input wire logic powered, // Digital path on
    input wire logic bclk_in, // Synchronised bit clock
    input wire logic ws_in, // Synchronised word select
    input wire logic sdin, // Synchronised serial data in
    input wire dap_pkg::dap_pair_t tx_pair, // Samples to send
    output logic tx_take, // Pulse: tx_pair latched
    output logic bclk_out, // Bit clock drive
    output logic bclk_oe, // Bit clock enable
    output logic ws_out, // Word select drive
    output logic ws_oe, // Word select enable
    output logic sdout, // Serial data out
    output logic sdout_oe, // Serial data enable
    output dap_pkg::dap_pair_t rx_pair, // Received samples
    output logic rx_valid // Pulse: rx_pair updated
);
    import dap_pkg::*;

    logic [15:0] gen_cnt, next_gen_cnt;
    logic gen_bclk, next_gen_bclk;
    logic [5:0] gen_bit, next_gen_bit;
    logic bclk_d, next_bclk_d;
    logic ws_d, next_ws_d;
    logic [4:0] slot, next_slot;
    logic [31:0] tx_sh, next_tx_sh;
    logic [23:0] rx_sh, next_rx_sh;
    dap_pair_t hold, next_hold;
    dap_pair_t rx_r, next_rx_r;
    logic sd_r, next_sd_r;
    logic [2:0] warm, next_warm;
    logic [31:0] ld;
    logic rxv, next_rxv, take, next_take;
    logic [15:0] half;
    logic bc, ws_eff, rise, fall, ws_edge, master;
    logic [5:0] wlen;

    // Data width from the word length code
    function automatic logic [5:0] width_of(input logic [1:0] c);
        case (c)
            2'h1: width_of = 6'd20;
            2'h2: width_of = 6'd24;
            default: width_of = 6'd16;
        endcase
    endfunction

    // Place a 24-bit sample in a 32-bit slot as framing asks
    function automatic logic [31:0] place(input logic [23:0] s, input logic [1:0] f, input logic [5:0] w);
        logic [31:0] v;
        logic [23:0] t;
        t = s & ~(24'hffffff >> w); // Bits below the word length dropped
        v = {t, 8'h00};
        if (f == DAP_FMT_RIGHT) begin
            v = {8'h00, s} >> (6'd24 - w);
            v = v & ((32'h1 << w) - 32'h1);
        end else if (f == DAP_FMT_I2S) begin
            v = {1'b0, t, 7'h00};
        end
        place = v;
    endfunction

    assign master = link_cfg.role_select;
    assign wlen = width_of(word_cfg.word_length_sel);
    // Base half period scaled by divider and multiplier
    always_comb begin
        half = (word_cfg.reference_rate_sel ? 16'(DAP_HALF44) : 16'(DAP_HALF48)) * 16'({3'h0, word_cfg.divider} + 6'd1);
        if (word_cfg.rate_multiplier == 2'h1) begin
            half = half >> 1;
        end
    end

    always_comb begin
        next_gen_cnt = gen_cnt + 16'h1;
        next_gen_bclk = gen_bclk;
        next_gen_bit = gen_bit;
        if (!master || !powered) begin
            next_gen_cnt = 16'h0;
            next_gen_bclk = 1'b0;
            next_gen_bit = 6'h0;
        end else if (gen_cnt + 16'h1 >= half) begin
            next_gen_cnt = 16'h0;
            next_gen_bclk = !gen_bclk;
            if (gen_bclk) begin
                next_gen_bit = gen_bit + 6'h1;
            end
        end
    end

    // Polarity applied before edge search
    assign bc = (master ? gen_bclk : bclk_in) ^ link_cfg.serial_clock_invert;
    assign ws_eff = (master ? gen_bit[5] : ws_in) ^ link_cfg.word_select_invert;
    // Edges ignored until the synchronised pins have settled after reset
    assign rise = bc && !bclk_d && warm[2];
    assign fall = !bc && bclk_d && warm[2];
    assign ws_edge = rise && (ws_eff != ws_d);

    always_comb begin
        next_bclk_d = bc;
        next_ws_d = rise ? ws_eff : ws_d;
        next_warm = {warm[1:0], 1'b1};
        next_slot = slot;
        next_tx_sh = tx_sh;
        next_rx_sh = rx_sh;
        next_hold = hold;
        next_rx_r = rx_r;
        next_sd_r = sd_r;
        next_rxv = 1'b0;
        next_take = 1'b0;
        ld = 32'h0;
        if (rise) begin
            next_slot = ws_edge ? 5'h0 : slot + 5'h1;
            if (ws_edge) begin
                // Left-align to 24 bits: truncated or zero-padded
                if (ws_d) begin
                    next_rx_r.right = rx_sh << (6'd24 - wlen);
                    next_rxv = link_cfg.receive_enable && powered;
                end else begin
                    next_rx_r.left = rx_sh << (6'd24 - wlen);
                end
                next_rx_sh = 24'h0;
            end
            // Sample only inside the word window; a new word starts empty so its MSB is kept
            if (link_cfg.receive_enable && powered) begin
                if (((link_cfg.framing_sel == DAP_FMT_I2S) ? (next_slot >= 5'h1 && next_slot <= 5'(wlen)) :
                     (link_cfg.framing_sel == DAP_FMT_RIGHT) ? (next_slot >= 5'(6'd32 - wlen)) :
                     (next_slot < 5'(wlen)))) begin
                    next_rx_sh = {(ws_edge ? 23'h0 : rx_sh[22:0]), sdin};
                end
            end
        end
        if (fall) begin
            next_sd_r = tx_sh[31];
            next_tx_sh = {tx_sh[30:0], 1'b0};
            // Channel change caught on the launch edge, else every word leaves a bit late
            if (ws_eff != ws_d) begin
                if (!ws_eff) begin
                    next_take = 1'b1;
                    next_hold = link_cfg.channel_swap ? {tx_pair.right, tx_pair.left} : tx_pair;
                end
                ld = place(ws_eff ? hold.right : (link_cfg.channel_swap ? tx_pair.right : tx_pair.left),
                           link_cfg.framing_sel, wlen);
                next_sd_r = ld[31];
                next_tx_sh = {ld[30:0], 1'b0};
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            gen_cnt <= 16'h0;
            gen_bclk <= 1'b0;
            gen_bit <= 6'h0;
            bclk_d <= 1'b0;
            ws_d <= 1'b0;
            slot <= 5'h0;
            tx_sh <= 32'h0;
            rx_sh <= 24'h0;
            hold <= '0;
            rx_r <= '0;
            sd_r <= 1'b0;
            warm <= 3'h0;
            rxv <= 1'b0;
            take <= 1'b0;
        end else begin
            gen_cnt <= next_gen_cnt;
            gen_bclk <= next_gen_bclk;
            gen_bit <= next_gen_bit;
            bclk_d <= next_bclk_d;
            ws_d <= next_ws_d;
            slot <= next_slot;
            tx_sh <= next_tx_sh;
            rx_sh <= next_rx_sh;
            hold <= next_hold;
            rx_r <= next_rx_r;
            sd_r <= next_sd_r;
            warm <= next_warm;
            rxv <= next_rxv;
            take <= next_take;
        end
    end

    assign bclk_out = gen_bclk;
    assign ws_out = gen_bit[5];
    assign bclk_oe = master && powered;
    assign ws_oe = master && powered;
    assign sdout = sd_r;
    assign sdout_oe = link_cfg.transmit_enable && powered;
    assign rx_pair = rx_r;
    assign rx_valid = rxv;
    assign tx_take = take;

    tx_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_cfg.transmit_enable |-> !sdout_oe) else $error("Data driven while transmit disabled");
    rx_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_cfg.receive_enable |=> !rx_valid) else $error("Receive pulse while disabled");
    slave_clock_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !link_cfg.role_select |-> !bclk_oe && !ws_oe) else $error("Slave drives link clocks");
endmodule

// file: rtl/dap_top.sv
// Purpose: Register file and two serial audio ports with power control
// Assumes: Register port is a plain strobe write, combinational read
// Notes: Link pins are sampled by sys_clk through two flip-flops
`timescale 1ns/10ps

module dap_top
    import dap_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic nrst, // Sync reset, active low
    input wire logic reg_wr, // Register write strobe
    input wire logic [7:0] reg_addr, // Register offset
    input wire logic [7:0] reg_wdata, // Write data
    output logic [7:0] reg_rdata, // Read data
    input wire logic [1:0] bclk_pin_in, // Bit clock pin level, per port
    output logic [1:0] bclk_pin_out, // Bit clock drive, per port
    output logic [1:0] bclk_pin_oe, // Bit clock enable, per port
    input wire logic [1:0] ws_pin_in, // Word select pin level
    output logic [1:0] ws_pin_out, // Word select drive
    output logic [1:0] ws_pin_oe, // Word select enable
    input wire logic [1:0] sdin_pin, // Serial data in
    output logic [1:0] sdout_pin, // Serial data out
    output logic [1:0] sdout_pin_oe, // Serial data enable
    input wire dap_pkg::dap_pair_t [1:0] tx_pair, // Samples to send
    output logic [1:0] tx_take, // Pulse: samples taken
    output dap_pkg::dap_pair_t [1:0] rx_pair, // Samples received
    output logic [1:0] rx_valid, // Pulse: samples received
    output logic [1:0] recorder_rate_sel, // Recorder reference_rate_sel
    output logic [5:0] recorder_a_setup, // Divider, multiplier of recorder a
    output logic [1:0] recorder_a_width, // Recorder a width code
    output dap_pkg::dap_gross_t gross_off, // Gross power controls
    output dap_pkg::dap_chan_t chan_off // Channel power controls
);
    import dap_pkg::*;

    dap_word_t word_r [2], next_word [2];
    dap_link_t link_r [2], next_link [2];
    dap_gross_t gross_r, next_gross;
    dap_chan_t chan_r, next_chan;
    logic [2:0] s1 [2], s2 [2];

    // Port index of a word or link register, one-hot hit
    function automatic logic [3:0] port_hit(input logic [7:0] a);
        port_hit = {a == DAP_OFS_B_LINK, a == DAP_OFS_B_WORD, a == DAP_OFS_A_LINK, a == DAP_OFS_A_WORD};
    endfunction

    always_comb begin
        logic [3:0] h;
        h = port_hit(reg_addr);
        for (int p = 0; p < 2; p++) begin
            next_word[p] = word_r[p];
            next_link[p] = link_r[p];
            if (reg_wr && h[2 * p]) begin
                next_word[p] = reg_wdata;
            end
            if (reg_wr && h[2 * p + 1]) begin
                next_link[p] = reg_wdata;
            end
        end
        next_gross = gross_r;
        next_chan = chan_r;
        if (reg_wr && reg_addr == DAP_OFS_GROSS) begin
            next_gross = reg_wdata;
        end
        if (reg_wr && reg_addr == DAP_OFS_CHAN) begin
            next_chan = reg_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int p = 0; p < 2; p++) begin
                word_r[p] <= DAP_RST_REG;
                link_r[p] <= DAP_RST_REG;
            end
            gross_r <= DAP_RST_REG;
            chan_r <= DAP_RST_REG;
        end else begin
            for (int p = 0; p < 2; p++) begin
                word_r[p] <= next_word[p];
                link_r[p] <= next_link[p];
            end
            gross_r <= next_gross;
            chan_r <= next_chan;
        end
    end

    always_comb begin
        logic [3:0] h;
        h = port_hit(reg_addr);
        reg_rdata = 8'h00;
        if (h[0]) reg_rdata = word_r[0];
        if (h[1]) reg_rdata = link_r[0];
        if (h[2]) reg_rdata = word_r[1];
        if (h[3]) reg_rdata = link_r[1];
        if (reg_addr == DAP_OFS_GROSS) reg_rdata = gross_r;
        if (reg_addr == DAP_OFS_CHAN) reg_rdata = chan_r;
    end

    // Pin synchronisers; only stage two is read
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int p = 0; p < 2; p++) begin
                s1[p] <= 3'h0;
                s2[p] <= 3'h0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                s1[p] <= {bclk_pin_in[p], ws_pin_in[p], sdin_pin[p]};
                s2[p] <= s1[p];
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_port
            dap_port u_port (
                .sys_clk(sys_clk),
                .nrst(nrst),
                .word_cfg(word_r[g]),
                .link_cfg(link_r[g]),
                // Standby and digital power-down both stop the link
                .powered(!gross_r.digital_path_off && !gross_r.standby),
                .bclk_in(s2[g][2]),
                .ws_in(s2[g][1]),
                .sdin(s2[g][0]),
                .tx_pair(tx_pair[g]),
                .tx_take(tx_take[g]),
                .bclk_out(bclk_pin_out[g]),
                .bclk_oe(bclk_pin_oe[g]),
                .ws_out(ws_pin_out[g]),
                .ws_oe(ws_pin_oe[g]),
                .sdout(sdout_pin[g]),
                .sdout_oe(sdout_pin_oe[g]),
                .rx_pair(rx_pair[g]),
                .rx_valid(rx_valid[g])
            );
        end
    endgenerate

    // Recorder a setup and width follow port a; rate select carries both ports
    assign recorder_rate_sel = {word_r[1].reference_rate_sel, word_r[0].reference_rate_sel};
    assign recorder_a_setup = {word_r[0].rate_multiplier, word_r[0].divider, word_r[0].reference_rate_sel};
    assign recorder_a_width = word_r[0].word_length_sel;
    assign gross_off = gross_r;
    assign chan_off = chan_r;

    gross_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == DAP_OFS_GROSS |=> gross_off == $past(reg_wdata)) else $error("Gross write lost");
    chan_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == DAP_OFS_CHAN |=> chan_off == $past(reg_wdata)) else $error("Channel write lost");
    standby_quiet_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        gross_off.standby |-> sdout_pin_oe == 2'h0) else $error("Link active in standby");
    second_port_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == DAP_OFS_B_LINK |=> reg_addr != DAP_OFS_B_LINK || reg_rdata == $past(reg_wdata))
        else $error("Second port link register not at its offset");
    swap_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        reg_wr && reg_addr == DAP_OFS_A_LINK |=> link_r[0].channel_swap == $past(reg_wdata[DAP_SWAP_BIT]))
        else $error("Swap bit not stored");
endmodule

// file: testbench/dap_peer.sv
// Purpose: Far-side serial audio peer that supplies clocks to a slave port
// Assumes: Device port in slave role; 160 ns bit clock
// Notes: Clock stands still between runs; released data line shows the inverted last bit
`timescale 1ns/10ps
module dap_peer (
    output logic bclk, // Bit clock to device
    output logic ws, // Word select to device
    output logic sd, // Serial data to device
    input wire logic sdout // Serial data from device
);
    logic [23:0] got_l;
    logic [23:0] got_r;
    initial begin
        bclk = 1'b1;
        ws = 1'b1;
        sd = 1'b0;
        got_l = 24'h000000;
        got_r = 24'h000000;
    end
    // Lag 1 puts the MSB one bit clock after the ws edge, 0 aligns it; st is the data start within the slot
    task automatic run(input int frames, input int lag, input int st, input logic wsi, input logic cki,
                       input logic [23:0] l, input logic [23:0] r);
        int b;
        int s;
        bclk = ~cki;
        ws = ~wsi;
        for (int k = 0; k <= 64 * frames; k++) begin
            #80;
            bclk = cki;
            ws = ((k % 64) >= 32) ^ wsi;
            b = k - lag;
            s = b % 32;
            if (b >= 0 && s >= st && s < st + 24) begin
                sd = ((b % 64) < 32) ? l[23 - (s - st)] : r[23 - (s - st)];
            end else begin
                sd = ~sd;
            end
            #80;
            bclk = ~cki;
            if (b >= 64 * (frames - 1) && b < 64 * frames && s >= st && s < st + 24) begin
                if ((b % 64) < 32) got_l[23 - (s - st)] = sdout;
                else got_r[23 - (s - st)] = sdout;
            end
        end
        sd = ~sd;
    endtask
endmodule

// file: testbench/testbench.sv
// Purpose: Self-checking bench for register file, power gates and both serial ports
// Assumes: Register writes are one-cycle strobes, reads combinational
// Notes: Peer covers standard framing timing; frame two of each run with the receiver on is the one checked
`timescale 1ns/10ps
module testbench;
    import dap_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic reg_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic [1:0] bclk_out, bclk_oe, ws_out, ws_oe, sdout, sdout_oe, tx_take, rx_valid;
    logic [1:0] p_bclk, p_ws, p_sd, bclk_w, ws_w;
    logic last_b = 1'b0;
    logic last_w = 1'b0;
    dap_pair_t [1:0] tx_pair = {48'h9d2b46e7a518, 48'h5a1e87c3e10f};
    dap_pair_t [1:0] rx_pair;
    dap_gross_t gross_off;
    dap_chan_t chan_off;
    logic [1:0] rec_width;
    logic [1:0] rec_rate;
    logic [5:0] rec_setup;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rxv = 0;
    int edges = 0;
    int wedges = 0;
    int takes = 0;
    logic [7:0] offs [6] = '{8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hd1, 8'hd2};
    logic [7:0] vals [6] = '{8'h9e, 8'h5b, 8'h6d, 8'hb7, 8'h3f, 8'ha5};
    logic [6:0] cases [7] = '{7'h02, 7'h26, 7'h42, 7'h12, 7'h0e, 7'h00, 7'h01};
    logic [7:0] rates [4] = '{8'h00, 8'h80, 8'h04, 8'h20};
    int rate_edges [4] = '{68, 64, 34, 136};

    assign bclk_w = (bclk_oe & bclk_out) | (~bclk_oe & p_bclk);
    assign ws_w = (ws_oe & ws_out) | (~ws_oe & p_ws);

    always #5 sys_clk = ~sys_clk;

    dap_peer pa (.bclk(p_bclk[0]), .ws(p_ws[0]), .sd(p_sd[0]), .sdout(sdout[0]));
    dap_peer pb (.bclk(p_bclk[1]), .ws(p_ws[1]), .sd(p_sd[1]), .sdout(sdout[1]));

    dap_top DUT (.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .bclk_pin_in(bclk_w), .bclk_pin_out(bclk_out), .bclk_pin_oe(bclk_oe),
        .ws_pin_in(ws_w), .ws_pin_out(ws_out), .ws_pin_oe(ws_oe), .sdin_pin(p_sd), .sdout_pin(sdout),
        .sdout_pin_oe(sdout_oe), .tx_pair(tx_pair), .tx_take(tx_take), .rx_pair(rx_pair), .rx_valid(rx_valid),
        .recorder_rate_sel(rec_rate), .recorder_a_setup(rec_setup), .recorder_a_width(rec_width),
        .gross_off(gross_off), .chan_off(chan_off));

    task automatic stop_test();
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Timeout well above the roughly 24k cycles the sequence needs; falling edge sees settled outputs
    always @(negedge sys_clk) begin
        cyc++;
        if (rx_valid[0] === 1'b1) rxv++;
        if (tx_take[0] === 1'b1) takes++;
        last_b <= bclk_out[0];
        last_w <= ws_out[0];
        if (bclk_out[0] !== last_b) edges++;
        if (ws_out[0] !== last_w) wedges++;
        if (cyc == 40000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        @(posedge sys_clk);
        #1;
        check("reg read", {40'h0, reg_rdata}, {40'h0, exp});
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 6; i++) rd(offs[i], 8'h00);
        check("tx enable out of reset", {46'h0, sdout_oe}, 48'h0);
        check("clock enable out of reset", {46'h0, bclk_oe}, 48'h0);
        // Receiver disabled: two full frames must not produce a sample
        pa.run(2, 1, 0, 1'b0, 1'b0, 24'h123456, 24'h654321);
        check("rx pulses while disabled", rxv, 0);
        for (int i = 0; i < 6; i++) wr(offs[i], vals[i]);
        wr(8'hcd, 8'hff);
        for (int i = 0; i < 6; i++) rd(offs[i], vals[i]);
        rd(8'hcd, 8'h00);
        check("gross controls", {40'h0, gross_off}, 48'h3f);
        check("channel controls", {40'h0, chan_off}, 48'ha5);
        check("recorder width", {46'h0, rec_width}, 48'h2);
        check("recorder rate", {46'h0, rec_rate}, 48'h1);
        check("recorder setup", {42'h0, rec_setup}, 48'h0f);
        for (int i = 0; i < 6; i++) wr(offs[i], 8'h00);
        wr(DAP_OFS_A_LINK, 8'h80);
        check("tx enable on", {47'h0, sdout_oe[0]}, 48'h1);
        wr(DAP_OFS_GROSS, 8'h02);
        check("tx gated by digital off", {47'h0, sdout_oe[0]}, 48'h0);
        wr(DAP_OFS_GROSS, 8'h20);
        check("tx gated by standby", {47'h0, sdout_oe[0]}, 48'h0);
        wr(DAP_OFS_GROSS, 8'h00);
        for (int i = 0; i < 7; i++) begin
            automatic logic [1:0] fmt = cases[i][6:5];
            automatic logic wsi = cases[i][4];
            automatic logic cki = cases[i][3];
            automatic logic swp = cases[i][2];
            automatic logic [1:0] wl = cases[i][1:0];
            automatic logic [23:0] m = (wl == 2'h0) ? 24'hffff00 : (wl == 2'h1) ? 24'hfffff0 : 24'hffffff;
            automatic logic [23:0] l = 24'ha5c3f1 ^ {21'h0, i[2:0]};
            automatic logic [23:0] r = 24'h3c96e2;
            wr(DAP_OFS_A_WORD, {6'h00, wl});
            wr(DAP_OFS_A_LINK, {1'b1, 1'b0, cki, wsi, swp, 1'b1, fmt});
            takes = 0;
            pa.run(2, (fmt == DAP_FMT_I2S) ? 1 : 0, (fmt == DAP_FMT_RIGHT) ? 8 : 0, wsi, cki, l, r);
            repeat (8) @(posedge sys_clk);
            check("tx take pulses", (takes >= 2 && takes <= 3), 48'h1);
            check("rx pair", rx_pair[0], {l & m, r & m});
            check("tx left slot", {24'h0, pa.got_l & m}, {24'h0, (swp ? 24'hc3e10f : 24'h5a1e87) & m});
            check("tx right slot", {24'h0, pa.got_r & m}, {24'h0, (swp ? 24'h5a1e87 : 24'hc3e10f) & m});
        end
        wr(DAP_OFS_B_WORD, 8'h02);
        wr(DAP_OFS_B_LINK, 8'h84);
        pb.run(2, 1, 0, 1'b0, 1'b0, 24'h1e2d3c, 24'h4b5a69);
        repeat (8) @(posedge sys_clk);
        check("port b rx pair", rx_pair[1], 48'h1e2d3c4b5a69);
        check("port b tx pair", {pb.got_l, pb.got_r}, 48'h9d2b46e7a518);
        wr(DAP_OFS_A_LINK, 8'h40);
        for (int i = 0; i < 4; i++) begin
            wr(DAP_OFS_A_WORD, rates[i]);
            repeat (200) @(posedge sys_clk);
            edges = 0;
            wedges = 0;
            repeat (1088) @(posedge sys_clk);
            check("master clock enable", {47'h0, bclk_oe[0]}, 48'h1);
            check("master word select enable", {47'h0, ws_oe[0]}, 48'h1);
            check("word select rate", (wedges * 64 <= edges + 64 && wedges * 64 + 64 >= edges), 48'h1);
            check("bit clock rate", (edges >= rate_edges[i] - 2 && edges <= rate_edges[i] + 2), 48'h1);
        end
        stop_test();
    end
endmodule
